// ==== acc_conv_ctrl.sv ====
// converter conversion control: control register, start source, tracking
// assumes core sfr bus writes/reads of one byte, and a sar converter
// that reports end of conversion and window match as one-cycle pulses
//
// Summary of operation
// - enable low keeps converter in shutdown; high lets conversions start
// - normal mode with converter enabled: track except during conversion
// - normal mode: conversion begins at once on the start event
// - delayed mode: three sar clocks of tracking precede conversion
// - done flag sets at conversion end, stays until software clears it
// - busy bit reads 1 during delayed-mode tracking and during conversion, else 0
// - writing 1 to busy starts only with source 000; 0 does nothing
// - source 000: software busy write is the only trigger
// - sources 001, 010, 011 start on timer 0, 2, 1 overflow
// - source 101 starts on each timer 3 overflow
// - source 100 starts on each rising edge of external strobe
`timescale 1ns/1ps
module acc_conv_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_sel,
  input wire acc_pkg::acc_tmr_type i_tmr_ovf,
  input wire logic i_ext_convert_strobe,
  input wire logic i_sar_clk_tick,
  input wire logic i_sar_done,
  input wire logic i_window_match,
  output logic o_conv_powered,
  output logic o_tracking,
  output logic o_conv_start,
  output logic o_conv_busy
);
  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} acc_state_type;

  acc_state_type state_r, state_nxt;
  acc_pkg::acc_ctrl_type ctrl_r, ctrl_nxt;
  logic [1:0] trk_cnt_r, trk_cnt_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic strobe_rise;
  logic hit;
  logic wr_sel;
  logic sw_start;
  logic start_evt;
  logic [7:0] wd;

  // external strobe crossing and edge detection
  acc_sync_edge u_strobe (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_async(i_ext_convert_strobe),
    .o_rise(strobe_rise)
  );

  assign hit = (i_sfr_addr == acc_pkg::CONV_CTRL_ADDR);
  assign wr_sel = i_sfr_wr & hit;
  assign wd = i_sfr_wdata;
  // software start only on a 1 written to busy with source 000
  assign sw_start = wr_sel & wd[acc_pkg::BUSY_BIT]
    & (wd[2:0] == acc_pkg::SRC_SW)
    & (ctrl_r.start_source_select == acc_pkg::SRC_SW);

  // start event mux from the selected source
  always_comb begin
    case (ctrl_r.start_source_select)
      acc_pkg::SRC_SW: start_evt = sw_start;
      acc_pkg::SRC_T0: start_evt = i_tmr_ovf.t0;
      acc_pkg::SRC_T2: start_evt = i_tmr_ovf.t2;
      acc_pkg::SRC_T1: start_evt = i_tmr_ovf.t1;
      acc_pkg::SRC_STRB: start_evt = strobe_rise;
      acc_pkg::SRC_T3: start_evt = i_tmr_ovf.t3;
      default: start_evt = 1'b0; // reserved codes
    endcase
  end

  // conversion sequencer next state
  always_comb begin
    state_nxt = state_r;
    trk_cnt_nxt = trk_cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (ctrl_r.conv_enable && start_evt) begin
          if (ctrl_r.track_delay_select) begin
            state_nxt = ST_TRACK;
            trk_cnt_nxt = 2'h0;
          end else begin
            state_nxt = ST_CONV;
          end
        end
      end
      ST_TRACK: begin
        if (i_sar_clk_tick) begin
          if (trk_cnt_r == acc_pkg::TRACK_SAR_CLKS - 2'h1) begin
            state_nxt = ST_CONV;
          end else begin
            trk_cnt_nxt = trk_cnt_r + 2'h1;
          end
        end
      end
      ST_CONV: begin
        if (i_sar_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (!ctrl_r.conv_enable) begin
      state_nxt = ST_IDLE; // shutdown aborts
    end
  end

  // control register next value; hardware set wins over software clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_sel) begin
      ctrl_nxt.conv_enable = wd[acc_pkg::EN_BIT];
      ctrl_nxt.track_delay_select = wd[acc_pkg::TM_BIT];
      ctrl_nxt.conv_done_flag = wd[acc_pkg::DONE_BIT];
      ctrl_nxt.window_match_flag = wd[acc_pkg::WIN_BIT];
      ctrl_nxt.start_source_select = wd[2:0];
    end
    if (state_r == ST_CONV && i_sar_done) begin
      ctrl_nxt.conv_done_flag = 1'b1;
    end
    if (state_r == ST_CONV && i_sar_done && i_window_match) begin
      ctrl_nxt.window_match_flag = 1'b1;
    end
    ctrl_nxt.conv_busy = (state_nxt != ST_IDLE);
  end

  // read data register
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_sfr_rd && hit) begin
      rdata_nxt = ctrl_r;
    end
  end

  // registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_r <= ST_IDLE;
      ctrl_r <= acc_pkg::CONV_CTRL_RST;
      trk_cnt_r <= 2'h0;
      rdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      trk_cnt_r <= trk_cnt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // converter outputs
  assign o_sfr_rdata = rdata_r;
  assign o_sfr_sel = hit;
  assign o_conv_powered = ctrl_r.conv_enable;
  assign o_tracking = ctrl_r.conv_enable && state_r != ST_CONV;
  assign o_conv_start = (state_r != ST_CONV) && (state_nxt == ST_CONV);
  assign o_conv_busy = ctrl_r.conv_busy;

  // assertions
  AST_SHUTDOWN: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !ctrl_r.conv_enable |=> state_r == ST_IDLE)
    else $error("conversion ran while disabled");
  AST_TRACK: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    ctrl_r.conv_enable && state_r == ST_IDLE |-> o_tracking)
    else $error("not tracking while idle and enabled");
  AST_IMMED: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_r == ST_IDLE && ctrl_r.conv_enable && !ctrl_r.track_delay_select
    && start_evt |=> state_r == ST_CONV)
    else $error("normal mode start not immediate");
  AST_DELAY: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(state_r == ST_CONV) && ctrl_r.track_delay_select
    |-> $past(trk_cnt_r) == 2'h2)
    else $error("delayed tracking length wrong");
  AST_DONE: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_r == ST_CONV && i_sar_done |=> ctrl_r.conv_done_flag)
    else $error("done flag not set");
  AST_BUSY: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    i_sfr_rd && hit
    |=> o_sfr_rdata[acc_pkg::BUSY_BIT] == $past(state_r != ST_IDLE))
    else $error("busy bit read does not match sequencer");
  AST_SWSTART: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    sw_start && ctrl_r.conv_enable && state_r == ST_IDLE
    |=> ctrl_r.conv_busy)
    else $error("software start did not make the converter busy");
  AST_WIN: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_r == ST_CONV && i_sar_done && i_window_match
    |=> ctrl_r.window_match_flag)
    else $error("window flag not set");
  AST_RSVD: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    ctrl_r.start_source_select[2:1] == 2'h3 |-> !start_evt)
    else $error("start on reserved source");
  AST_STRB: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    strobe_rise |=> !strobe_rise)
    else $error("strobe edge gave two starts");
endmodule // acc_conv_ctrl

// ==== acc_pkg.sv ====
// package for the converter conversion control block
// assumes an 8-bit special function register bus from the processor core
package acc_pkg;
  // register address and reset
  localparam logic [7:0] CONV_CTRL_ADDR = 8'he8;
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  // field positions
  localparam int EN_BIT = 7;
  localparam int TM_BIT = 6;
  localparam int DONE_BIT = 5;
  localparam int BUSY_BIT = 4;
  localparam int WIN_BIT = 3;
  // start source codes
  localparam logic [2:0] SRC_SW = 3'h0;
  localparam logic [2:0] SRC_T0 = 3'h1;
  localparam logic [2:0] SRC_T2 = 3'h2;
  localparam logic [2:0] SRC_T1 = 3'h3;
  localparam logic [2:0] SRC_STRB = 3'h4;
  localparam logic [2:0] SRC_T3 = 3'h5;
  // extra tracking in delayed mode, in sar clock periods
  localparam logic [1:0] TRACK_SAR_CLKS = 2'h3;

  // control register contents
  typedef struct packed {
    logic conv_enable;
    logic track_delay_select;
    logic conv_done_flag;
    logic conv_busy;
    logic window_match_flag;
    logic [2:0] start_source_select;
  } acc_ctrl_type;

  // timer overflow pulses
  typedef struct packed {
    logic t0;
    logic t1;
    logic t2;
    logic t3;
  } acc_tmr_type;
endpackage

// ==== acc_sync_edge.sv ====
// two-flop synchroniser with rising edge detector
// assumes i_async comes from a pin outside the system clock domain
`timescale 1ns/1ps
module acc_sync_edge (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_async,
  output logic o_rise
);
  logic s1_r, s1_nxt;
  logic s2_r, s2_nxt;
  logic s3_r, s3_nxt;

  // next values: only s2 reads s1
  always_comb begin
    s1_nxt = i_async;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  // registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  // one pulse per synchronised rising edge
  assign o_rise = s2_r & ~s3_r;
endmodule // acc_sync_edge

// ==== acc_sar_model.sv ====
// behavioural sar converter facing the conversion control block
// assumes i_busy is high only while a conversion runs, not while tracking
`timescale 1ns/1ps
module acc_sar_model (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_busy,
  input wire logic i_match,
  output logic o_tick,
  output logic o_done,
  output logic o_match
);
  logic [1:0] div_r;
  logic [3:0] cnt_r;
  // sar clock divider and conversion length counter
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      div_r <= 2'h0;
      cnt_r <= 4'h0;
    end else begin
      div_r <= div_r + 2'h1;
      cnt_r <= i_busy ? cnt_r + 4'h1 : 4'h0;
    end
  end
  // tick every fourth cycle, done after eight busy cycles
  assign o_tick = (div_r == 2'h3);
  assign o_done = i_busy && (cnt_r == 4'h8);
  // match only meaningful with done, inverted otherwise
  assign o_match = o_done ? i_match : ~i_match;
endmodule // acc_sar_model

// ==== acc_conv_ctrl_test.sv ====
// testbench for the conversion control block
// assumes the sar model stands in for the converter
`timescale 1ns/1ps
module acc_conv_ctrl_test;
  logic clk = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0;
  logic strb = 1'h0, match = 1'h0;
  logic [7:0] addr = 8'he8, wdata = 8'h00, rdata;
  acc_pkg::acc_tmr_type tmr = '0;
  logic sel, pwr, trk, start, busy, tick, done, wmatch;
  logic [2:0] srcs [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
  logic [3:0] tmrs [4] = '{4'h8, 4'h2, 4'h4, 4'h1};
  int error_cnt = 0, samples_checked = 0, n;
  int n_start = 0;
  // 200 mhz system clock
  always #2.5 clk = ~clk;
  acc_conv_ctrl dut_u (.i_sys_clk(clk), .i_srst(srst), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .o_sfr_sel(sel), .i_tmr_ovf(tmr),
    .i_ext_convert_strobe(strb), .i_sar_clk_tick(tick),
    .i_sar_done(done), .i_window_match(wmatch), .o_conv_powered(pwr),
    .o_tracking(trk), .o_conv_start(start), .o_conv_busy(busy));
  acc_sar_model sar_u (.i_sys_clk(clk), .i_srst(srst), .i_busy(busy & ~trk),
    .i_match(match), .o_tick(tick), .o_done(done), .o_match(wmatch));
  // count conversion start pulses handed to the converter
  always @(posedge clk)
    if (start === 1'h1) n_start <= n_start + 1;
  // counts and verdict
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'h1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'h0;
  endtask
  // one-cycle read, data compared a cycle later
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd = 1'h1;
    addr = a;
    @(negedge clk);
    rd = 1'h0;
    chk(rdata, exp);
  endtask
  // bounded wait on busy or tracking
  task automatic wait_for(input bit use_trk, input logic lvl,
                          output int cnt);
    cnt = 0;
    while ((use_trk ? trk : busy) !== lvl) begin
      @(negedge clk);
      cnt++;
      if (cnt > 40) begin
        error_cnt++;
        stop_test();
      end
    end
  endtask
  // timer pulse and strobe level, then one settling cycle
  task automatic pulse(input logic [3:0] t, input logic s);
    @(negedge clk);
    tmr = t;
    strb = s;
    @(negedge clk);
    tmr = 4'h0;
    @(negedge clk);
  endtask
  // whole conversion then register readback
  task automatic expect_conv(input logic [7:0] val);
    wait_for(0, 1'h1, n);
    wait_for(0, 1'h0, n);
    rd_reg(8'he8, val);
  endtask
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'h0;
    rd_reg(8'he8, 8'h00);
    rd_reg(8'h55, 8'h00);
    chk(sel, 8'h00);
    wr_reg(8'he8, 8'h10);
    chk({pwr, trk, busy}, 8'h00);
    chk(sel, 8'h01);
    wr_reg(8'he8, 8'h80);
    chk({pwr, trk, busy}, 8'h06);
    match = 1'h1;
    wr_reg(8'he8, 8'h90);
    chk({trk, busy}, 8'h01);
    expect_conv(8'ha8);
    rd_reg(8'he8, 8'ha8);
    match = 1'h0;
    wr_reg(8'he8, 8'h91);
    repeat (2) @(negedge clk);
    chk(busy, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'he8, 8'h80 | {5'h00, srcs[i]});
      pulse(~tmrs[i], 1'h0);
      chk(busy, 8'h00);
      pulse(tmrs[i], 1'h0);
      expect_conv(8'ha0 | {5'h00, srcs[i]});
    end
    for (int c = 6; c < 8; c++) begin
      wr_reg(8'he8, 8'h80 | c[7:0]);
      pulse(4'hf, 1'h1);
      pulse(4'h0, 1'h0);
      chk(busy, 8'h00);
    end
    wr_reg(8'he8, 8'h84);
    pulse(4'h0, 1'h1);
    expect_conv(8'ha4);
    repeat (20) @(negedge clk);
    chk(busy, 8'h00);
    pulse(4'h0, 1'h0);
    wr_reg(8'he8, 8'hc0);
    wr_reg(8'he8, 8'hd0);
    chk(trk, 8'h01);
    wait_for(1, 1'h0, n);
    chk(n >= 9 && n <= 12, 8'h01);
    expect_conv(8'he0);
    wr_reg(8'he8, 8'h80);
    wr_reg(8'he8, 8'h90);
    rd_reg(8'he8, 8'h90);
    wr_reg(8'he8, 8'h00);
    @(negedge clk);
    chk({trk, busy}, 8'h00);
    rd_reg(8'he8, 8'h00);
    chk(n_start[7:0], 8'h08);
    stop_test();
  end
endmodule // acc_conv_ctrl_test
